/* serial_flash_program_erase_tb_top.sv */
`timescale 1ns/1ns
module serial_flash_program_erase_tb_top;
  import sfp_pkg::*;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic cv = 1'b0, ae = 1'b0, qd = 1'b0, rd = 1'b0, wv = 1'b0, qe = 1'b0, ps = 1'b0, pk = 1'b0;
  logic [7:0] op = 8'h00, wd = 8'h00, rdat, pdat, e_v, g_v, keep;
  logic [23:0] ad = 24'h000000;
  logic [8:0] len = 9'h000;
  logic [3:0] bpl = 4'h0, lock = 4'h0;
  logic [9:0] pa = 10'h000;
  logic crdy, wrdy, rvld, busy, write_latch, pm, bpm;
  logic [7:0] dat [8];
  logic [7:0] exp_q [$];
  int fail_count = 0, comparisons = 0;
  sfp_if link ();
  sfp_host u_sfp_host (.core_clk_i(core_clk_i), .reset_i(reset_i), .link(link.host), .cmd_valid_i(cv),
    .cmd_op_i(op), .cmd_addr_i(ad), .cmd_addr_en_i(ae), .cmd_quad_i(qd), .cmd_wr_len_i(len), .cmd_rd_i(rd),
    .cmd_ready_o(crdy), .wr_valid_i(wv), .wr_data_i(wd), .wr_ready_o(wrdy), .rd_data_o(rdat), .rd_valid_o(rvld));
  sfp_device u_sfp_device (.core_clk_i(core_clk_i), .reset_i(reset_i), .link(link.device), .quad_enable_i(qe),
    .protect_scheme_select_i(ps), .block_protect_level_i(bpl), .page_lock_i(lock), .peek_addr_i(pa),
    .peek_data_o(pdat), .busy_flag_o(busy), .write_latch_o(write_latch), .pair_mode_o(pm), .busy_pin_mode_o(bpm));
  sfp_link_properties u_sfp_link_properties (.core_clk_i(core_clk_i), .reset_i(reset_i), .sclk(link.sclk),
    .cs_n(link.cs_n), .h_io(link.h_io), .h_oe_n(link.h_oe_n), .d_io(link.d_io), .d_oe_n(link.d_oe_n), .io(link.io));
  initial begin
    forever #4 core_clk_i = ~core_clk_i;
  end
  // ------------------------------
  // Reporting and result watcher
  // ------------------------------
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic bad(input string m);
    fail_count++;
    $display("BAD %0t %s", $time, m);
  endtask
  task automatic flag(input logic g, input logic e, input string m);
    comparisons++;
    if (g !== e) bad(m);
  endtask
  always @(posedge core_clk_i) begin
    if (rvld === 1'b1 || pk) begin
      comparisons++;
      e_v = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
      g_v = (rvld === 1'b1) ? rdat : pdat;
      if (g_v !== e_v) begin
        bad($sformatf("got %h want %h", g_v, e_v));
      end
    end
  end
  // ------------------------------
  // Host port, busy wait and peek port tasks
  // ------------------------------
  task automatic cmd(input logic [7:0] o, input logic [23:0] a, input logic e, q, r, input int n);
    int i = 0;
    for (int k = 0; k < n; k++) begin
      @(negedge core_clk_i);
      dat[k] = 8'($urandom);
      wv = 1'b1;
      wd = dat[k];
    end
    @(negedge core_clk_i);
    wv = 1'b0;
    if (n == 8) begin
      comparisons++;
      if (wrdy !== 1'b0) bad("buffer took a ninth word");
    end
    op = o;
    ad = a;
    ae = e;
    qd = q;
    rd = r;
    len = 9'(n);
    cv = 1'b1;
    @(negedge core_clk_i);
    cv = 1'b0;
    while (crdy !== 1'b1) begin
      @(negedge core_clk_i);
      i++;
      if (i > 5000) begin
        bad("command hung");
        close_out();
      end
    end
  endtask
  task automatic wen();
    cmd(OP_WRITE_ENABLE, '0, 0, 0, 0, 0);
  endtask
  task automatic rd_chk(input logic [7:0] o, input logic [7:0] v);
    exp_q.push_back(v);
    cmd(o, '0, 0, 0, 1, 0);
  endtask
  task automatic wait_idle();
    int i = 0;
    repeat (4) @(negedge core_clk_i);
    while (busy !== 1'b0) begin
      @(negedge core_clk_i);
      i++;
      if (i > 4000) begin
        bad("busy stuck");
        close_out();
      end
    end
  endtask
  task automatic peek(input logic [9:0] a, input logic [7:0] v);
    @(negedge core_clk_i);
    pa = a;
    @(negedge core_clk_i);
    exp_q.push_back(v);
    pk = 1'b1;
    @(negedge core_clk_i);
    pk = 1'b0;
  endtask
  task automatic area(input logic [9:0] b, input int n, input logic ok);
    for (int k = 0; k < n; k++) peek({b[9:8], 8'(b[7:0] + k)}, ok ? dat[k] : 8'hff);
  endtask
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    int s;
    s = $urandom(95);
    repeat (16) @(negedge core_clk_i);
    reset_i = 1'b0;
    for (int i = 0; i < 2; i++) begin
      wen();
      cmd(i ? OP_ERASE_ALL_B : OP_ERASE_ALL_A, '0, 0, 0, 0, 0);
      flag(busy, 1'b1, "erase not busy");
      rd_chk(OP_STATUS_READ, 8'h03);
      wait_idle();
      rd_chk(OP_STATUS_READ, 8'h00);
    end
    peek(10'($urandom), 8'hff);
    cmd(OP_PAGE_PROGRAM, 24'h000010, 1, 0, 0, 2);
    wait_idle();
    area(10'h010, 2, 0);
    wen();
    cmd(OP_PAGE_PROGRAM, 24'h0000fe, 1, 0, 0, 8);
    rd_chk(OP_STATUS_READ, 8'h03);
    wait_idle();
    rd_chk(OP_STATUS_READ, 8'h00);
    area(10'h0fe, 8, 1);
    peek(10'h006, 8'hff);
    keep = dat[0];
    for (int i = 0; i < 2; i++) begin
      qe = 1'(i);
      wen();
      cmd(OP_QUAD_PAGE_PROGRAM, 24'h000120, 1, 1, 0, 3);
      wait_idle();
      area(10'h120, 3, qe);
    end
    ps = 1'b1;
    lock = 4'h4;
    wen();
    cmd(OP_PAGE_PROGRAM, 24'h000200, 1, 0, 0, 2);
    wait_idle();
    rd_chk(OP_STATUS_READ, 8'h00);
    area(10'h200, 2, 0);
    ps = 1'b0;
    lock = 4'h0;
    bpl = 4'h1;
    wen();
    cmd(OP_ERASE_ALL_A, '0, 0, 0, 0, 0);
    wait_idle();
    rd_chk(OP_STATUS_READ, 8'h00);
    peek(10'h0fe, keep);
    bpl = 4'h0;
    wen();
    cmd(OP_PAIR_PROGRAM, 24'h000280, 1, 0, 0, 2);
    wait_idle();
    area(10'h280, 2, 1);
    cmd(OP_ERASE_ALL_A, '0, 0, 0, 0, 0);
    rd_chk(OP_STATUS_READ, 8'h02);
    cmd(OP_PAIR_PROGRAM, '0, 0, 0, 0, 3);
    wait_idle();
    area(10'h282, 2, 1);
    peek(10'h284, 8'hff);
    cmd(OP_PAIR_PROGRAM, '0, 0, 0, 0, 1);
    wait_idle();
    peek(10'h284, 8'hff);
    rd_chk(OP_SECURITY_READ, 8'h10);
    cmd(OP_BUSY_PIN_ENABLE, '0, 0, 0, 0, 0);
    flag(bpm, 1'b0, "busy pin taken in pair mode");
    cmd(OP_WRITE_DISABLE, '0, 0, 0, 0, 0);
    rd_chk(OP_SECURITY_READ, 8'h00);
    cmd(OP_BUSY_PIN_ENABLE, '0, 0, 0, 0, 0);
    wen();
    cmd(OP_PAIR_PROGRAM, 24'h0002a0, 1, 0, 0, 2);
    wait_idle();
    flag(pm, 1'b1, "pair mode off");
    flag(bpm, 1'b1, "busy pin mode off");
    rd_chk(OP_STATUS_READ, 8'hff);
    cmd(OP_RESET_ARM, '0, 0, 0, 0, 0);
    cmd(OP_RESET, '0, 0, 0, 0, 0);
    flag(pm, 1'b0, "reset kept pair mode");
    flag(write_latch, 1'b0, "reset kept latch");
    flag(bpm, 1'b0, "reset kept busy pin");
    wen();
    cmd(OP_PAIR_PROGRAM, 24'h0003fe, 1, 0, 0, 2);
    wait_idle();
    area(10'h3fe, 2, 1);
    rd_chk(OP_SECURITY_READ, 8'h00);
    rd_chk(OP_STATUS_READ, 8'h00);
    close_out();
  end
endmodule

/* sfp_device.sv */
`timescale 1ns/1ns
module sfp_device (
  input wire logic core_clk_i,
  input wire logic reset_i,
  sfp_if.device link,
  input wire logic quad_enable_i,
  input wire logic protect_scheme_select_i,
  input wire logic [3:0] block_protect_level_i,
  input wire logic [sfp_pkg::NUM_PAGES-1:0] page_lock_i,
  input wire logic [sfp_pkg::MEM_AW-1:0] peek_addr_i,
  output logic [7:0] peek_data_o,
  output logic busy_flag_o,
  output logic write_latch_o,
  output logic pair_mode_o,
  output logic busy_pin_mode_o
);
  import sfp_pkg::*;

  // ----------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------
  logic [2:0] ck_sy_q;
  logic [2:0] cs_sy_q;
  logic [3:0] io_sy0_q;
  logic [3:0] io_sy1_q;
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ck_sy_q <= 3'b000;
      cs_sy_q <= 3'b111;
      io_sy0_q <= 4'hf;
      io_sy1_q <= 4'hf;
    end else begin
      ck_sy_q <= {ck_sy_q[1:0], link.sclk};
      cs_sy_q <= {cs_sy_q[1:0], link.cs_n};
      io_sy0_q <= link.io;
      io_sy1_q <= io_sy0_q;
    end
  end
  logic csel;
  logic rise;
  logic fall;
  logic cs_fall;
  logic cs_rise;
  assign csel = !cs_sy_q[1];
  assign rise = csel && ck_sy_q[1] && !ck_sy_q[2];
  assign fall = csel && !ck_sy_q[1] && ck_sy_q[2];
  assign cs_fall = !cs_sy_q[1] && cs_sy_q[2];
  assign cs_rise = cs_sy_q[1] && !cs_sy_q[2];

  function automatic logic page_prot(input logic sch, input logic [3:0] lvl,
                                     input logic [NUM_PAGES-1:0] lk, input logic [PAGE_SEL_W-1:0] pg);
    if (sch) begin
      return lk[pg];
    end
    return (int'(pg) + int'(lvl)) >= NUM_PAGES;
  endfunction

  // ----------------------------------------
  // Frame decoder
  // ----------------------------------------
  sfp_cycle_t st_q;
  logic cp_q;
  logic [7:0] sh_q;
  logic [2:0] bit_q;
  logic [2:0] nbyte_q;
  logic [8:0] ndata_q;
  logic [7:0] op_q;
  logic [23:0] addr_q;
  logic [PAGE_AW-1:0] wptr_q;
  logic [7:0] d0_q;
  logic [7:0] d1_q;
  logic quad;
  logic no_addr;
  logic [7:0] sh_nx;
  logic [2:0] bit_nx;
  logic byte_done;
  logic is_data;
  logic idle;
  assign idle = (st_q == ST_IDLE);
  assign quad = (op_q == OP_QUAD_PAGE_PROGRAM) && (nbyte_q != 3'd0); // R13
  assign no_addr = cp_q && (op_q == OP_PAIR_PROGRAM); // R19
  assign sh_nx = quad ? {sh_q[3:0], io_sy1_q} : {sh_q[6:0], io_sy1_q[0]};
  assign bit_nx = bit_q + (quad ? 3'd4 : 3'd1);
  assign byte_done = rise && (bit_nx == 3'd0);
  assign is_data = no_addr ? (nbyte_q != 3'd0) : (nbyte_q == 3'd4);

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sh_q <= 8'h00;
      bit_q <= 3'd0;
      nbyte_q <= 3'd0;
      ndata_q <= 9'd0;
      op_q <= 8'h00;
      addr_q <= 24'h000000;
      wptr_q <= 8'h00;
      d0_q <= 8'hff;
      d1_q <= 8'hff;
    end else if (cs_fall) begin
      bit_q <= 3'd0;
      nbyte_q <= 3'd0;
      ndata_q <= 9'd0;
    end else if (rise) begin
      sh_q <= sh_nx;
      bit_q <= bit_nx;
      if (byte_done) begin
        if (nbyte_q != 3'd4) begin
          nbyte_q <= nbyte_q + 3'd1;
        end
        if (nbyte_q == 3'd0) begin
          op_q <= sh_nx;
        end else if (!is_data) begin
          addr_q <= {addr_q[15:0], sh_nx}; // R6
          if (nbyte_q == 3'd3) begin
            wptr_q <= sh_nx;
          end
        end else begin
          if (ndata_q != 9'd256) begin
            ndata_q <= ndata_q + 9'd1;
          end
          wptr_q <= wptr_q + 8'h01; // R7
          if (idle && ndata_q == 9'd0) begin
            d0_q <= sh_nx; // R15
          end
          if (idle && ndata_q == 9'd1) begin
            d1_q <= sh_nx; // R16
          end
        end
      end
    end
  end

  // ----------------------------------------
  // Page staging buffer
  // ----------------------------------------
  logic [7:0] pg_buf_q [0:(1<<PAGE_AW)-1];
  logic [(1<<PAGE_AW)-1:0] pg_vld_q;
  logic pg_wr;
  assign pg_wr = byte_done && is_data && idle && !no_addr;
  always_ff @(posedge core_clk_i) begin
    if (pg_wr) begin
      pg_buf_q[wptr_q] <= sh_nx; // R8
    end
  end
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pg_vld_q <= '0;
    end else if (cs_fall && idle) begin
      pg_vld_q <= '0;
    end else if (pg_wr) begin
      pg_vld_q[wptr_q] <= 1'b1; // R9
    end
  end

  // ----------------------------------------
  // Command execution and self-timed cycles
  // ----------------------------------------
  logic latch_q;
  logic ry_q;
  logic arm_q;
  logic [BUSY_W-1:0] cnt_q;
  logic [MEM_AW-1:0] sweep_q;
  logic [MEM_AW-1:0] cp_addr_q;
  logic [PAGE_SEL_W-1:0] pg_q;
  logic op_ok;
  logic exec;
  logic [MEM_AW-1:0] tgt;
  logic [MEM_AW-1:0] cp_nx;
  logic prot_any;
  assign op_ok = !cp_q || op_q inside {OP_PAIR_PROGRAM, OP_WRITE_DISABLE, OP_STATUS_READ,
                                       OP_SECURITY_READ, OP_RESET_ARM, OP_RESET}; // R18
  assign exec = cs_rise && (bit_q == 3'd0) && (nbyte_q != 3'd0) && op_ok; // R2 R10
  assign tgt = cp_q ? cp_addr_q : {addr_q[MEM_AW-1:1], 1'b0};
  assign cp_nx = cp_addr_q + MEM_AW'(2);
  assign prot_any = protect_scheme_select_i ? (|page_lock_i) : (block_protect_level_i != 4'h0);

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_q <= ST_IDLE;
      latch_q <= 1'b0;
      cp_q <= 1'b0;
      ry_q <= 1'b0;
      arm_q <= 1'b0;
      cnt_q <= '0;
      sweep_q <= '0;
      cp_addr_q <= '0;
      pg_q <= '0;
    end else if (!idle) begin
      sweep_q <= sweep_q + MEM_AW'(1);
      cnt_q <= cnt_q - BUSY_W'(1);
      if (cnt_q == BUSY_W'(1)) begin
        st_q <= ST_IDLE;
        if (st_q == ST_PAIR) begin
          cp_addr_q <= cp_nx; // R17
          if (cp_nx == '0 || page_prot(protect_scheme_select_i, block_protect_level_i, page_lock_i,
                                       cp_nx[MEM_AW-1:PAGE_AW])) begin
            cp_q <= 1'b0; // R17
            latch_q <= 1'b0;
          end
        end else begin
          latch_q <= 1'b0; // R3 R11
        end
      end
    end else if (exec) begin
      arm_q <= (op_q == OP_RESET_ARM) && (nbyte_q == 3'd1);
      sweep_q <= '0;
      unique case (op_q)
        OP_WRITE_ENABLE: latch_q <= latch_q | (nbyte_q == 3'd1);
        OP_WRITE_DISABLE: begin
          latch_q <= 1'b0; // R20
          cp_q <= 1'b0;
        end
        OP_BUSY_PIN_ENABLE: ry_q <= 1'b1; // R22
        OP_BUSY_PIN_DISABLE: ry_q <= 1'b0; // R22
        OP_RESET: if (arm_q) begin
          latch_q <= 1'b0; // R21
          cp_q <= 1'b0;
          ry_q <= 1'b0;
        end
        OP_ERASE_ALL_A, OP_ERASE_ALL_B: if (latch_q && nbyte_q == 3'd1) begin
          if (prot_any) begin
            latch_q <= 1'b0; // R4
          end else begin
            st_q <= ST_ERASE; // R1 R3
            cnt_q <= ERASE_ALL_CYC;
          end
        end
        OP_PAGE_PROGRAM, OP_QUAD_PAGE_PROGRAM: if (latch_q && nbyte_q == 3'd4 && ndata_q != 9'd0 &&
                                                   (op_q == OP_PAGE_PROGRAM || quad_enable_i)) begin // R5 R13
          if (page_prot(protect_scheme_select_i, block_protect_level_i, page_lock_i,
                        addr_q[MEM_AW-1:PAGE_AW])) begin
            latch_q <= 1'b0; // R12
          end else begin
            st_q <= ST_PROG; // R11
            cnt_q <= PAGE_WRITE_CYC;
            pg_q <= addr_q[MEM_AW-1:PAGE_AW];
          end
        end
        OP_PAIR_PROGRAM: if (latch_q && ndata_q >= 9'd2 && (cp_q || nbyte_q == 3'd4)) begin // R16
          cp_addr_q <= tgt;
          if (page_prot(protect_scheme_select_i, block_protect_level_i, page_lock_i,
                        tgt[MEM_AW-1:PAGE_AW])) begin
            latch_q <= 1'b0; // R12
            cp_q <= 1'b0;
          end else begin
            cp_q <= 1'b1;
            st_q <= ST_PAIR; // R15
            cnt_q <= PAIR_WRITE_CYC;
          end
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Array
  // ----------------------------------------
  logic [7:0] mem_q [0:(1<<MEM_AW)-1];
  logic [MEM_AW-1:0] pa;
  logic [MEM_AW-1:0] qa;
  assign pa = {pg_q, sweep_q[PAGE_AW-1:0]};
  assign qa = {cp_addr_q[MEM_AW-1:1], sweep_q[0]};
  always_ff @(posedge core_clk_i) begin
    peek_data_o <= mem_q[peek_addr_i];
    unique case (st_q)
      ST_IDLE: ;
      ST_ERASE: mem_q[sweep_q] <= 8'hff; // R1
      ST_PROG: if (pg_vld_q[sweep_q[PAGE_AW-1:0]]) begin
        mem_q[pa] <= mem_q[pa] & pg_buf_q[sweep_q[PAGE_AW-1:0]]; // R5 R9
      end
      ST_PAIR: mem_q[qa] <= mem_q[qa] & (sweep_q[0] ? d1_q : d0_q); // R15
    endcase
  end

  // ----------------------------------------
  // Serial output and user status
  // ----------------------------------------
  logic [7:0] out_sh_q;
  logic out_on_q;
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      out_sh_q <= 8'h00;
      out_on_q <= 1'b0;
      link.d_io <= 4'hf;
      link.d_oe_n <= ALL_OE_N;
      busy_flag_o <= 1'b0;
      write_latch_o <= 1'b0;
      pair_mode_o <= 1'b0;
      busy_pin_mode_o <= 1'b0;
    end else begin
      busy_flag_o <= !idle;
      write_latch_o <= latch_q;
      pair_mode_o <= cp_q;
      busy_pin_mode_o <= ry_q;
      if (!csel) begin
        out_on_q <= 1'b0;
        link.d_oe_n <= ALL_OE_N; // R22
      end else if (ry_q && cp_q) begin
        link.d_oe_n <= 4'b1101;
        link.d_io[1] <= idle; // R22
      end else if (byte_done && nbyte_q == 3'd0 && sh_nx == OP_STATUS_READ) begin
        out_sh_q <= 8'(({7'h00, latch_q} << STATUS_LATCH_BIT) | ({7'h00, !idle} << STATUS_BUSY_BIT));
        out_on_q <= 1'b1;
      end else if (byte_done && nbyte_q == 3'd0 && sh_nx == OP_SECURITY_READ) begin
        out_sh_q <= 8'({7'h00, cp_q} << SECURITY_PAIR_BIT); // R21
        out_on_q <= 1'b1;
      end else if (fall && out_on_q) begin
        link.d_oe_n <= 4'b1101;
        link.d_io[1] <= out_sh_q[7];
        out_sh_q <= {out_sh_q[6:0], out_sh_q[7]};
      end
    end
  end
endmodule

/* sfp_fifo.sv */
`timescale 1ns/1ns
module sfp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [0:DEPTH-1];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem_q[rp_q];
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem_q[wp_q] <= in_data_i;
    end
  end
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      in_ready_o <= 1'b1;
      out_valid_o <= 1'b0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      in_ready_o <= (cnt_q + (AW+1)'(push) - (AW+1)'(pop)) != (AW+1)'(DEPTH);
      out_valid_o <= (cnt_q + (AW+1)'(push) - (AW+1)'(pop)) != '0;
    end
  end
endmodule

/* sfp_host.sv */
`timescale 1ns/1ns
module sfp_host (
  input wire logic core_clk_i,
  input wire logic reset_i,
  sfp_if.host link,
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_op_i,
  input wire logic [23:0] cmd_addr_i,
  input wire logic cmd_addr_en_i,
  input wire logic cmd_quad_i,
  input wire logic [8:0] cmd_wr_len_i,
  input wire logic cmd_rd_i,
  output logic cmd_ready_o,
  input wire logic wr_valid_i,
  input wire logic [7:0] wr_data_i,
  output logic wr_ready_o,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o
);
  import sfp_pkg::*;

  function automatic logic [3:0] lanes(input logic [7:0] b, input logic q);
    return q ? b[7:4] : {3'b111, b[7]};
  endfunction

  logic f_valid;
  logic [7:0] f_data;
  logic f_pop;
  sfp_fifo #(.WIDTH(8), .DEPTH(8)) u_fifo (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .in_valid_i(wr_valid_i),
    .in_data_i(wr_data_i),
    .in_ready_o(wr_ready_o),
    .out_valid_o(f_valid),
    .out_data_o(f_data),
    .out_ready_i(f_pop)
  );

  logic [3:0] io_sy0_q;
  logic [3:0] io_sy1_q;
  sfp_host_st_t st_q;
  logic [3:0] div_q;
  logic [7:0] sh_q;
  logic [3:0] bits_q;
  logic [1:0] addr_left_q;
  logic [23:0] addr_sh_q;
  logic [8:0] data_left_q;
  logic rd_left_q;
  logic reading_q;
  logic quad_q;
  logic lane4_q;
  logic [7:0] rd_sh_q;
  logic tick;
  logic load;
  assign tick = (div_q == SCLK_HALF_CYC - 4'd1); // R14
  assign load = (st_q == H_SHIFT) && tick && !link.sclk && (bits_q == 4'd0);
  assign f_pop = load && (addr_left_q == 2'd0) && (data_left_q != 9'd0) && f_valid;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      io_sy0_q <= 4'hf;
      io_sy1_q <= 4'hf;
      st_q <= H_IDLE;
      div_q <= 4'd0;
      sh_q <= 8'h00;
      bits_q <= 4'd0;
      addr_left_q <= 2'd0;
      addr_sh_q <= 24'h000000;
      data_left_q <= 9'd0;
      rd_left_q <= 1'b0;
      reading_q <= 1'b0;
      quad_q <= 1'b0;
      lane4_q <= 1'b0;
      rd_sh_q <= 8'h00;
      cmd_ready_o <= 1'b1;
      rd_data_o <= 8'h00;
      rd_valid_o <= 1'b0;
      link.sclk <= 1'b0;
      link.cs_n <= 1'b1;
      link.h_io <= 4'hf;
      link.h_oe_n <= ALL_OE_N;
    end else begin
      io_sy0_q <= link.io;
      io_sy1_q <= io_sy0_q;
      rd_valid_o <= 1'b0;
      div_q <= (st_q == H_IDLE || tick) ? 4'd0 : div_q + 4'd1;
      unique case (st_q)
        H_IDLE: if (cmd_valid_i) begin // R6
          cmd_ready_o <= 1'b0;
          st_q <= H_SEL;
          link.cs_n <= 1'b0;
          link.h_oe_n <= SINGLE_OE_N;
          sh_q <= cmd_op_i;
          link.h_io <= lanes(cmd_op_i, 1'b0);
          bits_q <= 4'd8;
          lane4_q <= 1'b0;
          quad_q <= cmd_quad_i;
          addr_left_q <= cmd_addr_en_i ? 2'd3 : 2'd0;
          addr_sh_q <= cmd_addr_i;
          data_left_q <= cmd_wr_len_i;
          rd_left_q <= cmd_rd_i;
          reading_q <= 1'b0;
        end
        H_SEL: if (tick) begin
          st_q <= H_SHIFT;
        end
        H_SHIFT: if (tick) begin
          if (link.sclk) begin
            link.sclk <= 1'b0;
            if (bits_q != 4'd0) begin
              sh_q <= lane4_q ? {sh_q[3:0], 4'h0} : {sh_q[6:0], 1'b0};
              link.h_io <= lanes(lane4_q ? {sh_q[3:0], 4'h0} : {sh_q[6:0], 1'b0}, lane4_q);
            end
          end else if (bits_q != 4'd0) begin
            link.sclk <= 1'b1;
            bits_q <= bits_q - 4'd1;
            if (reading_q) begin
              rd_sh_q <= {rd_sh_q[6:0], io_sy1_q[1]};
            end
          end else if (addr_left_q != 2'd0) begin
            addr_left_q <= addr_left_q - 2'd1; // R13
            addr_sh_q <= {addr_sh_q[15:0], 8'h00};
            sh_q <= addr_sh_q[23:16];
            link.h_io <= lanes(addr_sh_q[23:16], quad_q);
            link.h_oe_n <= quad_q ? 4'b0000 : SINGLE_OE_N;
            lane4_q <= quad_q;
            bits_q <= quad_q ? 4'd2 : 4'd8;
          end else if (data_left_q != 9'd0) begin
            if (f_valid) begin
              data_left_q <= data_left_q - 9'd1;
              sh_q <= f_data;
              link.h_io <= lanes(f_data, quad_q);
              link.h_oe_n <= quad_q ? 4'b0000 : SINGLE_OE_N;
              lane4_q <= quad_q;
              bits_q <= quad_q ? 4'd2 : 4'd8;
            end
          end else if (rd_left_q) begin
            rd_left_q <= 1'b0;
            reading_q <= 1'b1;
            link.h_oe_n <= ALL_OE_N;
            bits_q <= 4'd8;
          end else begin
            st_q <= H_DESEL; // R10
            link.cs_n <= 1'b1;
            link.h_oe_n <= ALL_OE_N;
            rd_valid_o <= reading_q;
            rd_data_o <= rd_sh_q;
          end
        end
        H_DESEL: if (tick) begin
          st_q <= H_IDLE;
          cmd_ready_o <= 1'b1;
        end
      endcase
    end
  end
endmodule

/* sfp_if.sv */
`timescale 1ns/1ns
interface sfp_if;
  logic sclk;
  logic cs_n;
  logic [3:0] h_io;
  logic [3:0] h_oe_n;
  logic [3:0] d_io;
  logic [3:0] d_oe_n;
  logic [3:0] io;
  // Resolved lane level, pulled high when nobody drives
  assign io = (h_io & ~h_oe_n) | (d_io & ~d_oe_n) | (h_oe_n & d_oe_n);
  modport device(input sclk, input cs_n, input io, output d_io, output d_oe_n);
  modport host(output sclk, output cs_n, output h_io, output h_oe_n, input io);
endinterface

/* sfp_link_properties.sv */
`timescale 1ns/1ns
module sfp_link_properties (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] h_io,
  input wire logic [3:0] h_oe_n,
  input wire logic [3:0] d_io,
  input wire logic [3:0] d_oe_n,
  input wire logic [3:0] io
);
  import sfp_pkg::*;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  // ------------------------------
  // Frame pieces
  // ------------------------------
  sequence bit_high_s;
    sclk [*8] ##1 !sclk;
  endsequence
  sequence frame_lead_s;
    h_oe_n == SINGLE_OE_N ##1 !sclk [*7];
  endsequence
  sequence deselect_s;
    cs_n [*6];
  endsequence
  // ------------------------------
  // Link checks
  // ------------------------------
  clock_idle_a: assert property (cs_n |-> !sclk) else $error("clock active while deselected");
  clock_rate_a: assert property ($rose(sclk) |-> bit_high_s) else $error("clock high phase wrong");
  frame_end_a: assert property ($rose(cs_n) |-> !$past(sclk) && !$past(sclk, 7)) else $error("select rose mid bit");
  frame_start_a: assert property ($fell(cs_n) |-> frame_lead_s) else $error("frame start malformed");
  no_contention_a: assert property ((h_oe_n | d_oe_n) == 4'hf) else $error("both ends drive a lane");
  device_lanes_a: assert property (d_oe_n[0] && d_oe_n[2] && d_oe_n[3]) else $error("device drove input lane");
  output_float_a: assert property (deselect_s |-> d_oe_n[1]) else $error("output driven while deselected");
  reset_idle_a: assert property ($fell(reset_i) |-> cs_n && !sclk && io == 4'hf) else $error("link not idle");
endmodule

/* sfp_pkg.sv */
// Function
// R1 - Erase-all sets whole array to ones
// R2 - Erase-all needs select rise on byte boundary
// R3 - Erase-all runs timed, busy, then clears latch
// R4 - Any protection blocks erase-all, latch still cleared
// R5 - Page program clears bits, needs write latch
// R6 - Host sends opcode, three address bytes, data
// R7 - Data past page end wraps to page start
// R8 - Only final 256 bytes are kept
// R9 - Unsent page locations stay unchanged
// R10 - Program rejected unless select rises at byte end
// R11 - Page program timed, busy, then clears latch
// R12 - Protected page unchanged, latch still cleared
// R13 - Quad program needs quad enable, four lanes
// R14 - Host should slow quad clock below 70MHz
// R15 - Pair mode writes even then odd byte
// R16 - One byte ignored, bytes past two dropped
// R17 - Pair address advances, ends at top address
// R18 - Pair mode accepts only six opcodes
// R19 - Later pairs carry opcode and data only
// R20 - Write disable in pair mode waits for idle
// R21 - Security bit four shows pair mode
// R22 - Busy pin mode drives ready level on output; code drives it only while pair mode is on
package sfp_pkg;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_SECURITY_READ = 8'h2b;
  localparam logic [7:0] OP_ERASE_ALL_A = 8'h60;
  localparam logic [7:0] OP_ERASE_ALL_B = 8'hc7;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_QUAD_PAGE_PROGRAM = 8'h38;
  localparam logic [7:0] OP_PAIR_PROGRAM = 8'had;
  localparam logic [7:0] OP_RESET_ARM = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;
  localparam logic [7:0] OP_BUSY_PIN_ENABLE = 8'h70;
  localparam logic [7:0] OP_BUSY_PIN_DISABLE = 8'h80;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_LATCH_BIT = 1;
  localparam int SECURITY_PAIR_BIT = 4;
  localparam int MEM_AW = 10;
  localparam int PAGE_AW = 8;
  localparam int NUM_PAGES = 4;
  localparam int PAGE_SEL_W = MEM_AW - PAGE_AW;
  localparam int CLK_PERIOD_NS = 8;
  localparam int ERASE_ALL_TIME_US = 20;
  localparam int PAGE_WRITE_TIME_US = 10;
  localparam int PAIR_WRITE_TIME_US = 2;
  localparam int BUSY_W = 12;
  localparam logic [BUSY_W-1:0] ERASE_ALL_CYC = BUSY_W'(ERASE_ALL_TIME_US * 1000 / CLK_PERIOD_NS);
  localparam logic [BUSY_W-1:0] PAGE_WRITE_CYC = BUSY_W'(PAGE_WRITE_TIME_US * 1000 / CLK_PERIOD_NS);
  localparam logic [BUSY_W-1:0] PAIR_WRITE_CYC = BUSY_W'(PAIR_WRITE_TIME_US * 1000 / CLK_PERIOD_NS);
  localparam logic [3:0] SCLK_HALF_CYC = 4'd8;
  localparam logic [3:0] SINGLE_OE_N = 4'b1110;
  localparam logic [3:0] ALL_OE_N = 4'b1111;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_PROG = 2'b01, ST_PAIR = 2'b11, ST_ERASE = 2'b10} sfp_cycle_t;
  typedef enum logic [1:0] {H_IDLE = 2'b00, H_SEL = 2'b01, H_SHIFT = 2'b11, H_DESEL = 2'b10} sfp_host_st_t;
endpackage
